// ---- hw/eph_pkg.sv ----
// Purpose: Constants and types for the serial EEPROM write/protect host
// Assumes: 125 MHz aclk, open-drain SCL and SDA, one device on the bus
// Notes:   Register map is for the host's own AXI4-Lite slave port
//
// Contract
// - START is SDA falling with SCL high, STOP is SDA rising
// - Each byte is eight bits MSB first plus one acknowledge clock
// - Control code 1010 selects the main memory array
// - Control code 1011 selects security space including protect register
// - Three select bits must match the device's fixed all-zero or all-one
// - Last control bit is one for read, zero for write
// - High then low address byte; only bits 0-13 used, rest zero (host masks array space only; security space address goes out unmasked)
// - Every byte is acknowledged; no acknowledge means full restart
// - Write ends with STOP after last data acknowledge; no STOP, no write
// - Device ignores control bytes while programming, so master can poll
// - Page write keeps sending data then STOP; up to 64 bytes
// - Protect register: security space address 0401h, written as byte write
// - Protect register unchanged unless STOP follows its data byte
// - On first use master should clear both protect select bits

package eph_pkg;

  // ==========================================================
  // Register map (byte offsets)
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_ADDR     = 8'h04;
  localparam logic [7:0]  REG_DATA     = 8'h08;
  localparam logic [7:0]  REG_STATUS   = 8'h0c;

  // CTRL fields
  localparam int          CTRL_GO      = 0;
  localparam int          CTRL_SPACE   = 1;
  localparam int          CTRL_SELHI   = 2;
  localparam int          CTRL_POLL    = 3;
  localparam int          CTRL_LEN_LO  = 4;
  localparam int          LEN_W        = 7;
  // STATUS fields
  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_DONE    = 1;
  localparam int          STAT_NACK    = 2;
  localparam int          STAT_FILL_LO = 8;

  localparam logic [31:0] CTRL_RESET   = 32'h0000_0010;
  localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ==========================================================
  // Device addressing
  localparam logic [3:0]  CODE_MEM     = 4'ha;
  localparam logic [3:0]  CODE_SEC     = 4'hb;
  localparam logic [2:0]  SEL_LOW      = 3'h0;
  localparam logic [2:0]  SEL_HIGH     = 3'h7;
  localparam logic        RW_WRITE     = 1'h0;
  localparam logic [15:0] ADDR_MASK    = 16'h3fff;
  localparam logic [15:0] PROT_ADDR    = 16'h0401;
  localparam int          PAGE_BYTES   = 64;
  localparam int          BYTE_BITS    = 8;
  localparam int          HDR_BYTES    = 3;

  // ==========================================================
  // Timing: one quarter of a 400 kHz SCL period, rounded up
  localparam int          CLK_MHZ      = 125;
  localparam int          T_QUARTER_NS = 625;
  localparam int          Q_CYC        = (T_QUARTER_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_BIT   = 4'b0100,
    ST_STOP  = 4'b1000
  } eph_state_e;

  typedef struct packed {
    logic             space;
    logic             selhi;
    logic             poll;
    logic [LEN_W-1:0] len;
    logic [15:0]      addr;
  } eph_cmd_s;

endpackage : eph_pkg

// ---- hw/eph_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter for bus pins
// Assumes: Inputs idle high, as an open-drain bus does
// Notes:   Output moves only once stages two and three agree
`timescale 1ns/1ps

module eph_sync #(
  parameter int W = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ==========================================================
  // Capture chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // ==========================================================
  // Filter: a half-settled edge is held back one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout <= '1;
    end else begin
      dout <= (s2 & s3) | (dout & (s2 ^ s3));
    end
  end

endmodule : eph_sync

// ---- hw/eph_host.sv ----
// Purpose: I2C master that writes a serial EEPROM and its protect register
// Assumes: Software loads data bytes, address and then CTRL with GO
// Notes:   Reads of the device are not issued; poll mode probes busy state
`timescale 1ns/1ps

module eph_host #(
  parameter int unsigned QUARTER_CYC = eph_pkg::Q_CYC,
  parameter int unsigned DEPTH       = eph_pkg::PAGE_BYTES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             busy
);

  localparam int IW = $clog2(DEPTH);
  localparam int QW = $clog2(QUARTER_CYC + 1);
  localparam logic [QW-1:0] QLOAD = QW'(QUARTER_CYC - 1);
  localparam logic [eph_pkg::LEN_W-1:0] LEN_MAX =
    eph_pkg::LEN_W'(DEPTH);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  function automatic logic [7:0] ctrl_byte(input logic space,
                                           input logic selhi);
    ctrl_byte = {space ? eph_pkg::CODE_SEC : eph_pkg::CODE_MEM,
                 selhi ? eph_pkg::SEL_HIGH : eph_pkg::SEL_LOW,
                 eph_pkg::RW_WRITE};
  endfunction : ctrl_byte

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == eph_pkg::REG_CTRL) || (a == eph_pkg::REG_ADDR) ||
             (a == eph_pkg::REG_DATA) || (a == eph_pkg::REG_STATUS);
  endfunction : mapped

  // ==========================================================
  // State
  logic [31:0]        ctrl_reg;
  logic [31:0]        addr_reg;
  logic [7:0]         buffer [DEPTH];
  logic [IW-1:0]      fill;
  logic               go;
  logic               aw_held;
  logic               w_held;
  logic [7:0]         aw_a;
  logic [31:0]        w_d;
  logic [3:0]         w_s;
  logic               done;
  logic               nack;
  logic [1:0]         pins;
  logic               scl_s;
  logic               sda_s;
  eph_pkg::eph_state_e state;
  eph_pkg::eph_cmd_s  cmd;
  logic [1:0]         ph;
  logic [QW-1:0]      qcnt;
  logic               tick;
  logic [3:0]         bitn;
  logic [6:0]         byte_idx;
  logic [6:0]         n_total;
  logic [7:0]         shreg;
  logic [7:0]         next_byte;
  logic [15:0]        tx_addr;
  logic [IW-1:0]      bidx;
  logic [6:0]         boff;
  logic [eph_pkg::LEN_W-1:0] next_len;

  eph_sync #(
    .W (2)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({scl_i, sda_i}),
    .dout    (pins)
  );

  assign scl_s = pins[1];
  assign sda_s = pins[0];
  assign tick  = (qcnt == '0);

  // ==========================================================
  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= eph_pkg::RESP_OKAY;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_a     <= 8'h00;
      w_d      <= 32'h0000_0000;
      w_s      <= 4'h0;
      ctrl_reg <= eph_pkg::CTRL_RESET;
      addr_reg <= eph_pkg::ADDR_RESET;
      fill     <= '0;
      go       <= 1'b0;
    end else begin
      go <= 1'b0;
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_a    <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_d    <= wdata;
        w_s    <= wstrb;
        wready <= 1'b0;
      end
      if (aw_held && w_held && !bvalid) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= mapped(aw_a) ? eph_pkg::RESP_OKAY
                                : eph_pkg::RESP_SLVERR;
        case (aw_a)
          eph_pkg::REG_CTRL: begin
            // Settings are frozen while a transfer runs
            if (state == eph_pkg::ST_IDLE) begin
              ctrl_reg <= wmerge(ctrl_reg, w_d, w_s);
              go       <= w_s[0] && w_d[eph_pkg::CTRL_GO];
            end
          end
          eph_pkg::REG_ADDR: begin
            if (state == eph_pkg::ST_IDLE) begin
              addr_reg <= wmerge(addr_reg, w_d, w_s);
            end
          end
          eph_pkg::REG_DATA: begin
            if (w_s[0]) begin
              buffer[fill] <= w_d[7:0];
              fill         <= fill + 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      // Buffer refill restarts at slot zero once a transfer finishes
      if (state == eph_pkg::ST_STOP && ph == 2'd3 && tick) begin
        fill <= '0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= eph_pkg::RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= mapped(araddr) ? eph_pkg::RESP_OKAY
                                  : eph_pkg::RESP_SLVERR;
        rdata   <= 32'h0000_0000;
        case (araddr)
          eph_pkg::REG_CTRL: begin
            rdata <= ctrl_reg & ~(32'h1 << eph_pkg::CTRL_GO);
          end
          eph_pkg::REG_ADDR: begin
            rdata <= addr_reg;
          end
          eph_pkg::REG_STATUS: begin
            rdata[eph_pkg::STAT_BUSY] <= busy;
            rdata[eph_pkg::STAT_DONE] <= done;
            rdata[eph_pkg::STAT_NACK] <= nack;
            rdata[eph_pkg::STAT_FILL_LO +: IW] <= fill;
          end
          default: begin
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Launch values and byte sequencer
  always_comb begin
    next_len = ctrl_reg[eph_pkg::CTRL_LEN_LO +: eph_pkg::LEN_W];
    if (next_len == '0) begin
      next_len = eph_pkg::LEN_W'(1);
    end else if (next_len > LEN_MAX) begin
      next_len = LEN_MAX;
    end
  end

  // Upper address bits forced to zero in the array space
  assign tx_addr = cmd.space ? cmd.addr
                             : (cmd.addr & eph_pkg::ADDR_MASK);
  assign boff    = byte_idx + 7'd1 - 7'(eph_pkg::HDR_BYTES);
  assign bidx    = boff[IW-1:0];

  always_comb begin
    case (byte_idx + 7'd1)
      7'd1:    next_byte = tx_addr[15:8];
      7'd2:    next_byte = tx_addr[7:0];
      default: next_byte = buffer[bidx];
    endcase
  end

  // ==========================================================
  // Bit engine: four quarter phases per SCL period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= eph_pkg::ST_IDLE;
      cmd      <= '0;
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe   <= 1'b0;
      sda_oe   <= 1'b0;
      ph       <= 2'd0;
      qcnt     <= '0;
      bitn     <= 4'h0;
      byte_idx <= 7'h00;
      n_total  <= 7'h00;
      shreg    <= 8'h00;
      busy     <= 1'b0;
      done     <= 1'b0;
      nack     <= 1'b0;
    end else begin
      if (!tick) begin
        qcnt <= qcnt - 1'b1;
      end else if (state != eph_pkg::ST_IDLE) begin
        qcnt <= QLOAD;
        ph   <= ph + 2'd1;
      end
      case (state)
        eph_pkg::ST_IDLE: begin
          if (go) begin
            cmd.space <= ctrl_reg[eph_pkg::CTRL_SPACE];
            cmd.selhi <= ctrl_reg[eph_pkg::CTRL_SELHI];
            cmd.poll  <= ctrl_reg[eph_pkg::CTRL_POLL];
            cmd.len   <= next_len;
            cmd.addr  <= addr_reg[15:0];
            // Poll sends only the control byte and reads its acknowledge
            n_total   <= ctrl_reg[eph_pkg::CTRL_POLL] ? 7'd1
                         : 7'(eph_pkg::HDR_BYTES) + next_len;
            shreg     <= ctrl_byte(ctrl_reg[eph_pkg::CTRL_SPACE],
                                   ctrl_reg[eph_pkg::CTRL_SELHI]);
            byte_idx  <= 7'h00;
            busy      <= 1'b1;
            done      <= 1'b0;
            nack      <= 1'b0;
            ph        <= 2'd0;
            qcnt      <= QLOAD;
            state     <= eph_pkg::ST_START;
          end
        end
        eph_pkg::ST_START: begin
          if (tick) begin
            case (ph)
              2'd0: sda_oe <= 1'b1;
              2'd1: scl_oe <= 1'b1;
              default: begin
                ph    <= 2'd0;
                bitn  <= 4'h0;
                state <= eph_pkg::ST_BIT;
              end
            endcase
          end
        end
        eph_pkg::ST_BIT: begin
          // Wait for the line to go high, so a stretched SCL is honoured
          if (ph == 2'd2 && !scl_s) begin
            qcnt <= QLOAD;
            ph   <= ph;
          end else if (tick) begin
            case (ph)
              2'd0: begin
                // Ninth clock releases SDA for the device acknowledge
                sda_oe <= (bitn == 4'(eph_pkg::BYTE_BITS)) ? 1'b0
                          : !shreg[7];
              end
              2'd1: scl_oe <= 1'b0;
              2'd2: begin
                if (bitn == 4'(eph_pkg::BYTE_BITS)) begin
                  nack <= sda_s;
                end else begin
                  shreg <= {shreg[6:0], 1'b0};
                end
              end
              default: begin
                scl_oe <= 1'b1;
                if (bitn != 4'(eph_pkg::BYTE_BITS)) begin
                  bitn <= bitn + 4'h1;
                end else if (nack ||
                             byte_idx + 7'd1 == n_total) begin
                  // Abort on refusal; software restarts from control byte
                  state <= eph_pkg::ST_STOP;
                end else begin
                  byte_idx <= byte_idx + 7'd1;
                  shreg    <= next_byte;
                  bitn     <= 4'h0;
                end
              end
            endcase
          end
        end
        eph_pkg::ST_STOP: begin
          if (ph == 2'd2 && !scl_s) begin
            qcnt <= QLOAD;
            ph   <= ph;
          end else if (tick) begin
            case (ph)
              2'd0: sda_oe <= 1'b1;
              2'd1: scl_oe <= 1'b0;
              2'd2: sda_oe <= 1'b0;
              default: begin
                busy  <= 1'b0;
                done  <= 1'b1;
                state <= eph_pkg::ST_IDLE;
              end
            endcase
          end
        end
        default: begin
          state  <= eph_pkg::ST_IDLE;
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          busy   <= 1'b0;
        end
      endcase
    end
  end

endmodule : eph_host

// ---- sim/eph_host_chk.sv ----
// Purpose: Port-level checks on the EEPROM write host
// Assumes: One aclk domain, synchronous active-low reset
// Notes:   Sees only host ports; bound at the foot of this file
`timescale 1ns/1ps

module eph_host_chk #(
  parameter int unsigned QUARTER_CYC = eph_pkg::Q_CYC
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        busy
);
  localparam int QW = int'(2 * QUARTER_CYC + 8);
  logic [3:0] rel_cnt;
  logic       scl_q;
  logic       clocked;

  // ==========================================================
  // Release counter: the ninth SCL release of a byte is its ack clock
  always_ff @(posedge aclk) begin
    scl_q <= scl_oe;
    if (!aresetn || !busy) begin
      rel_cnt <= 4'h0;
      clocked <= 1'b0;
    end else begin
      if (scl_oe) clocked <= 1'b1;
      if (scl_q && !scl_oe) begin
        rel_cnt <= (rel_cnt == 4'h8) ? 4'h0 : rel_cnt + 4'h1;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_start;
    $rose(sda_oe) && !scl_oe;
  endsequence
  sequence s_stop;
    $fell(sda_oe) && !scl_oe;
  endsequence
  sequence s_ack_clk;
    $fell(scl_oe) && rel_cnt == 4'h8;
  endsequence

  a_start_first: assert property (
    s_start |-> !clocked ##[1:QW] $rose(scl_oe))
    else $error("start out of place or clock not driven after it");
  a_no_false_start: assert property (
    clocked && !scl_oe |-> !$rose(sda_oe))
    else $error("data line pulled while clock high");
  a_stop_ends: assert property (
    s_stop |-> ##[1:QW] !busy)
    else $error("busy stays after stop");
  a_ack_release: assert property (
    s_ack_clk |-> !sda_oe [*4])
    else $error("data line held in acknowledge clock");
  a_idle_quiet: assert property (
    !busy && !$past(busy) |-> !scl_oe && !sda_oe)
    else $error("bus driven while idle");
  a_b_follows: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("no write response");
  a_b_single: assert property (
    bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  a_r_follows: assert property (
    arvalid && arready |=> rvalid && !arready)
    else $error("no read response");
  a_r_single: assert property (
    rvalid && rready |=> !rvalid)
    else $error("read response repeated");
endmodule : eph_host_chk

bind eph_host eph_host_chk #(.QUARTER_CYC(QUARTER_CYC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .busy(busy)
);

// ---- sim/eph_dev.sv ----
// Purpose: Behavioural serial EEPROM slave with protect register
// Assumes: Open-drain bus with pull-ups resolved by the bench
// Notes:   Reads are not modelled, so a read control byte is not selected
`timescale 1ns/1ps

module eph_dev #(
  parameter logic [2:0] SEL     = 3'h0,
  parameter int         WORD_NS = 4000
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe
);
  logic [7:0]  mem [0:16383];
  logic [7:0]  pbuf [0:63];
  logic [7:0]  prot;
  logic [7:0]  sh;
  logic [15:0] ptr;
  logic        act;
  logic        sec;
  int          nbit;
  int          nbyte;
  realtime     free_at;

  // ==========================================================
  // Power-up: protection set so the host must clear it first
  initial begin
    sda_oe = 1'b0;
    act = 1'b0;
    prot = 8'h0c;
    free_at = 0;
    foreach (mem[i]) mem[i] = 8'h00;
  end

  function automatic logic locked(input logic [15:0] a);
    case (prot[3:2])
      2'h1: return a[13:12] == 2'h3;
      2'h2: return a[13];
      2'h3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : locked

  task automatic commit();
    int          n;
    logic [15:0] a;
    n = (nbyte - 3 > 64) ? 64 : nbyte - 3;
    if (sec) begin
      if (ptr == 16'h0401) prot = {4'h0, pbuf[0][3:2], 2'h0};
    end else if (ptr[15:14] == 2'h0) begin
      for (int i = 0; i < n; i++) begin
        a = {ptr[15:6], ptr[5:0] + 6'(i)};
        if (!locked(a)) mem[a[13:0]] = pbuf[i];
      end
    end
    // Word-granular busy time, so one byte costs a whole word
    free_at = $realtime + ((n + 3) / 4) * WORD_NS;
  endtask : commit

  task automatic take();
    if (nbyte == 0) begin
      sec = (sh[7:4] == 4'hb);
      act = (sh[7:4] == 4'ha || sec) && sh[3:1] == SEL
            && !sh[0] && $realtime >= free_at;
    end else if (nbyte == 1) ptr[15:8] = sh;
    else if (nbyte == 2) ptr[7:0] = sh;
    else pbuf[(nbyte - 3) % 64] = sh;
    if (act) begin
      nbyte++;
      sda_oe = 1'b1;
    end
  endtask : take

  // ==========================================================
  // Bus conditions and bit engine
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b1;
      nbit = 0;
      nbyte = 0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1 && act) begin
      act = 1'b0;
      if (nbyte > 3) commit();
    end
  end
  always @(posedge scl) begin
    if (act && nbit < 8) begin
      sh = {sh[6:0], sda};
      nbit++;
    end
  end
  always @(negedge scl) begin
    if (act && nbit == 9) begin
      sda_oe = 1'b0;
      nbit = 0;
    end else if (act && nbit == 8) begin
      nbit = 9;
      take();
    end
  end
endmodule : eph_dev

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the EEPROM write host
// Assumes: Short SCL quarter so the run stays brief
// Notes:   Device contents are read from the model by hierarchy
`timescale 1ns/1ps

module tb_top;
  localparam int QC = 4;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, busy;
  logic        dev_sda_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, stat;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          miscompares, samples_checked;

  // Pull-ups: a released line reads high
  assign scl_i = (scl_oe === 1'b1) ? scl_o : 1'b1;
  assign sda_i = ((sda_oe === 1'b1) ? sda_o : 1'b1) && dev_sda_oe !== 1'b1;

  eph_host #(.QUARTER_CYC(QC)) DUT (.*);
  eph_dev u_dev (.scl(scl_i), .sda(sda_i), .sda_oe(dev_sda_oe));

  always #4 aclk = ~aclk;

  // ==========================================================
  // Checks and closing
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk

  task automatic nack_is(input logic e);
    chk("nack", {31'h0, e}, {31'h0, stat[eph_pkg::STAT_NACK]});
  endtask : nack_is

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // ==========================================================
  // AXI4-Lite master
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // ==========================================================
  // Transfer helpers
  function automatic logic [31:0] mk(input logic sp, input logic sh,
                                     input logic pl, input int ln);
    return (32'(ln) << eph_pkg::CTRL_LEN_LO) | (32'(pl) << eph_pkg::CTRL_POLL)
         | (32'(sh) << eph_pkg::CTRL_SELHI) | (32'(sp) << eph_pkg::CTRL_SPACE);
  endfunction : mk

  task automatic xfer(input logic [31:0] ctl, input logic [15:0] a);
    logic [1:0] r;
    wr(eph_pkg::REG_ADDR, {16'h0, a}, 4'hf, r);
    wr(eph_pkg::REG_CTRL, ctl | (32'h1 << eph_pkg::CTRL_GO), 4'hf, r);
    do begin
      rd(eph_pkg::REG_STATUS, stat, r);
    end while (stat[eph_pkg::STAT_DONE] !== 1'b1);
  endtask : xfer

  task automatic bw(input logic sp, input logic [15:0] a,
                    input logic [7:0] v);
    logic [1:0] r;
    wr(eph_pkg::REG_DATA, {24'h0, v}, 4'hf, r);
    xfer(mk(sp, 1'b0, 1'b0, 1), a);
  endtask : bw

  // Acknowledge polling until the write cycle is over
  task automatic settle();
    do begin
      xfer(mk(1'b0, 1'b0, 1'b1, 1), 16'h0);
    end while (stat[eph_pkg::STAT_NACK] !== 1'b0);
  endtask : settle

  // ==========================================================
  // Scenarios
  task automatic run_tests();
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  v;
    logic [7:0]  e;
    logic [15:0] ad [3] = '{16'h3000, 16'h2000, 16'h1fff};
    rd(eph_pkg::REG_CTRL, d, r);
    chk("ctrl", eph_pkg::CTRL_RESET, d);
    rd(eph_pkg::REG_ADDR, d, r);
    chk("addr", eph_pkg::ADDR_RESET, d);
    rd(eph_pkg::REG_STATUS, d, r);
    chk("status", 32'h0, d);
    rd(8'h10, d, r);
    chk("rresp", {30'h0, eph_pkg::RESP_SLVERR}, {30'h0, r});
    chk("rdata", 32'h0, d);
    wr(8'h20, 32'h1, 4'hf, r);
    chk("bresp", {30'h0, eph_pkg::RESP_SLVERR}, {30'h0, r});
    // Protect codes, first pass clears the power-up protection
    for (int bp = 0; bp < 4; bp++) begin
      bw(1'b1, eph_pkg::PROT_ADDR, {4'hf, 2'(bp), 2'h3});
      chk("prot", {28'h0, 2'(bp), 2'h0}, {24'h0, u_dev.prot});
      settle();
      for (int k = 0; k < 3; k++) begin
        v = 8'(16 * bp + k + 1);
        e = (bp > k) ? u_dev.mem[ad[k][13:0]] : v;
        bw(1'b0, ad[k], v);
        nack_is(1'b0);
        chk("mem", {24'h0, e}, {24'h0, u_dev.mem[ad[k][13:0]]});
        settle();
      end
    end
    bw(1'b1, eph_pkg::PROT_ADDR, 8'h00);
    settle();
    bw(1'b0, 16'h01ff, 8'h5a);
    chk("mem", 32'h5a, {24'h0, u_dev.mem[14'h01ff]});
    xfer(mk(1'b0, 1'b0, 1'b1, 1), 16'h0);
    nack_is(1'b1);
    settle();
    nack_is(1'b0);
    bw(1'b0, 16'hc123, 8'h77);
    chk("mem", 32'h77, {24'h0, u_dev.mem[14'h0123]});
    settle();
    xfer(mk(1'b0, 1'b1, 1'b1, 1), 16'h0);
    nack_is(1'b1);
    xfer(mk(1'b1, 1'b0, 1'b1, 1), 16'h0);
    nack_is(1'b0);
    // Page write from mid-page, wrapping within the page
    for (int i = 0; i < 32; i++) wr(eph_pkg::REG_DATA, 32'h80 + i, 4'hf, r);
    wr(eph_pkg::REG_DATA, 32'h11, 4'he, r);
    rd(eph_pkg::REG_STATUS, d, r);
    chk("fill", 32'd32, {26'h0, d[eph_pkg::STAT_FILL_LO +: 6]});
    xfer(mk(1'b0, 1'b0, 1'b0, 32), 16'h0130);
    chk("fill", 32'h0, {26'h0, stat[eph_pkg::STAT_FILL_LO +: 6]});
    for (int i = 0; i < 32; i++) begin
      v = 8'(6'h30 + i);
      chk("page", 32'h80 + i, {24'h0, u_dev.mem[{8'h04, v[5:0]}]});
    end
    chk("edge", 32'h0, {24'h0, u_dev.mem[14'h0140]});
    xfer(mk(1'b0, 1'b0, 1'b1, 1), 16'h0);
    nack_is(1'b1);
    settle();
    chk("busy", 32'h0, {31'h0, busy});
  endtask : run_tests

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    miscompares = 0;
    samples_checked = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    run_tests();
    complete_run();
  end

  initial begin
    #700000;
    miscompares++;
    complete_run();
  end
endmodule : tb_top
